// [design/ulpm_top.sv]
/*
 * usb lpm control block: ahb-lite register slave, interrupt status,
 * and the link engine.
 * assumes a single ahb-lite master and that hready equals hreadyout.
 */
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ns
module ulpm_top
    import ulpm_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        host_mode,
    input  wire logic        lpm_rx,
    input  wire logic        tx_fifo_empty,
    input  wire logic        token_rx,
    input  wire logic        host_timeout,
    input  wire logic        suspend_end,
    output logic             resp_ack,
    output logic             resp_nyet,
    output logic             l1_enter,
    output logic             lpm_tx_start,
    output logic             sw_irq_pulse,
    output logic             irq,
    output logic      [3:0]  lpm_endpoint,
    output logic             remote_wake_enable,
    output logic      [3:0]  target_link_state,
    output logic      [15:0] resume_cycles
);
    ulpm_phase_type phase_q;       // data-phase tracker
    logic [7:0]     addr_q;        // latched address
    logic           addr_take;     // address phase accepted
    logic           ctrl_wr;       // write data phase to control
    logic           sleep_transition_request_q;
    logic [1:0]     lpm_response_enable_q;
    logic [3:0]     endpoint_q;
    logic           remote_wake_enable_q;
    logic [3:0]     host_resume_duration_q;
    logic [3:0]     target_link_state_q;
    logic [3:0]     stat_q;        // sticky events
    logic [3:0]     mask_q;        // interrupt enables
    logic [3:0]     ev;            // events this cycle
    logic           stat_rd_clr;   // status read clears
    logic [31:0]    ctrl_view;     // control register read image
    logic [31:0]    rd_mux;

    ulpm_link_if lk ();

    ulpm_engine u_eng (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .host_mode     (host_mode),
        .lpm_rx        (lpm_rx),
        .tx_fifo_empty (tx_fifo_empty),
        .token_rx      (token_rx),
        .host_timeout  (host_timeout),
        .resp_ack      (resp_ack),
        .resp_nyet     (resp_nyet),
        .l1_enter      (l1_enter),
        .lpm_tx_start  (lpm_tx_start),
        .lk            (lk)
    );

    // only whole-word single transfers; response always okay
    assign addr_take = hsel && htrans[1] && hready;
    assign hreadyout = (phase_q != PH_RD_WAIT); // reads take one wait state
    assign hresp     = 1'b0;
    assign ctrl_wr   = (phase_q == PH_WRITE) && (addr_q == CTRL_OFS);

    // data-phase sequencing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= PH_IDLE;
            addr_q  <= 8'h00;
        end else begin
            case (phase_q)
                PH_RD_WAIT: phase_q <= PH_RD_DONE; // no new address while stalled
                default: begin
                    if (addr_take) begin
                        addr_q  <= haddr;
                        phase_q <= hwrite ? PH_WRITE : PH_RD_WAIT;
                    end else begin
                        phase_q <= PH_IDLE;
                    end
                end
            endcase
        end
    end

    // link interface drives, from the write in its data phase
    assign lk.arm_set    = ctrl_wr && !host_mode && hwdata[REQ_BIT]
                           && (hwdata[EN_LSB +: 2] == EN_ARMED);
    assign lk.disarm     = ctrl_wr && !hwdata[REQ_BIT];
    assign lk.host_go    = ctrl_wr && host_mode && hwdata[REQ_BIT];
    assign lk.link_state = target_link_state_q;

    // control register; software write beats a same-cycle self-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_transition_request_q <= CTRL_RST[REQ_BIT];
            lpm_response_enable_q      <= CTRL_RST[EN_LSB +: 2];
            endpoint_q                 <= CTRL_RST[EP_LSB +: 4];
            remote_wake_enable_q       <= CTRL_RST[RWAKE_BIT];
            host_resume_duration_q     <= CTRL_RST[HOST_RESUME_DURATION_LSB +: 4];
            target_link_state_q        <= CTRL_RST[LSTATE_LSB +: 4];
        end else if (ctrl_wr) begin
            sleep_transition_request_q <= hwdata[REQ_BIT];
            lpm_response_enable_q      <= hwdata[EN_LSB +: 2];
            endpoint_q                 <= hwdata[EP_LSB +: 4];
            remote_wake_enable_q       <= hwdata[RWAKE_BIT];
            host_resume_duration_q     <= hwdata[HOST_RESUME_DURATION_LSB +: 4];
            target_link_state_q        <= hwdata[LSTATE_LSB +: 4];
        end else begin
            if (lk.self_clr) begin
                sleep_transition_request_q <= 1'b0;
            end
            if (suspend_end) begin
                remote_wake_enable_q <= 1'b0;
            end
        end
    end

    // minimum resume drive time in cycles, registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resume_cycles <= RESUME_BASE_CYC;
        end else begin
            resume_cycles <= RESUME_BASE_CYC
                           + 16'(host_resume_duration_q) * RESUME_STEP_CYC;
        end
    end

    // event collection; response events also pulse the core interrupt
    assign ev[EV_ACK]   = lk.ev_ack;
    assign ev[EV_NYET]  = lk.ev_nyet;
    assign ev[EV_HDONE] = lk.ev_hdone;
    assign ev[EV_HTMO]  = lk.ev_htmo;
    assign sw_irq_pulse = lk.ev_ack || lk.ev_nyet;

    assign stat_rd_clr = (phase_q == PH_RD_WAIT) && (addr_q == STAT_OFS);

    // sticky status: a new event wins over the read-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= 4'h0;
        end else if (stat_rd_clr) begin
            stat_q <= ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    // mask register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= MASK_RST;
        end else if ((phase_q == PH_WRITE) && (addr_q == MASK_OFS)) begin
            mask_q <= hwdata[3:0];
        end
    end

    assign irq = |(stat_q & mask_q);

    // read image; bits 11..9 and all unnamed bits read zero
    always_comb begin
        ctrl_view                      = 32'h0000_0000;
        ctrl_view[REQ_BIT]             = sleep_transition_request_q;
        ctrl_view[EN_LSB +: 2]         = lpm_response_enable_q;
        ctrl_view[EP_LSB +: 4]         = endpoint_q;
        ctrl_view[RWAKE_BIT]           = remote_wake_enable_q;
        ctrl_view[HOST_RESUME_DURATION_LSB +: 4]       = host_resume_duration_q;
        ctrl_view[LSTATE_LSB +: 4]     = target_link_state_q;
        case (addr_q)
            CTRL_OFS: rd_mux = ctrl_view;
            STAT_OFS: rd_mux = {28'h0000000, stat_q};
            MASK_OFS: rd_mux = {28'h0000000, mask_q};
            default:  rd_mux = 32'h0000_0000; // unmapped reads zero
        endcase
    end

    // read data captured in the wait cycle, held through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (phase_q == PH_RD_WAIT) begin
            hrdata <= rd_mux;
        end
    end

    assign lpm_endpoint       = endpoint_q;
    assign remote_wake_enable = remote_wake_enable_q;
    assign target_link_state  = target_link_state_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_ctrl_read_done;
        phase_q == PH_RD_WAIT && addr_q == CTRL_OFS ##1 phase_q == PH_RD_DONE;
    endsequence

    AST_UNIMPL_ZERO: assert property (s_ctrl_read_done |-> hrdata[11:9] == 3'h0)
        else $error("unimplemented control bits read nonzero");
    AST_ARM_SAME_WRITE: assert property (ctrl_wr && !host_mode && hwdata[REQ_BIT]
                                         && hwdata[EN_LSB +: 2] != EN_ARMED
                                         |=> !u_eng.armed_q)
        else $error("armed without enable in the same write");
    AST_ACK_CLEARS_REQ: assert property (lk.ev_ack && !ctrl_wr
                                         |-> sw_irq_pulse ##1 !sleep_transition_request_q)
        else $error("request bit kept after ack");
    AST_NYET_KEEPS_REQ: assert property (lk.ev_nyet && sleep_transition_request_q && !ctrl_wr
                                         |-> sw_irq_pulse ##1 sleep_transition_request_q)
        else $error("nyet cleared request or gave no interrupt");
    AST_IRQ_PULSE: assert property (sw_irq_pulse == $past(u_eng.take))
        else $error("response without interrupt pulse");
    AST_ZERO_WRITE_KEEPS: assert property (ctrl_wr && !hwdata[REQ_BIT] |=> !l1_enter)
        else $error("zero write changed link power state");
    AST_RESUME_TIME: assert property ($stable(host_resume_duration_q)
                                      |-> resume_cycles == RESUME_BASE_CYC
                                          + 16'(host_resume_duration_q) * RESUME_STEP_CYC)
        else $error("resume cycle count wrong");
    AST_RWAKE_ONCE: assert property (suspend_end && !ctrl_wr |=> !remote_wake_enable)
        else $error("remote wake kept past suspend");
    AST_EP_WRITE: assert property (ctrl_wr |=> lpm_endpoint == $past(hwdata[15:12]))
        else $error("endpoint field not written");
endmodule : ulpm_top

// [design/ulpm_pkg.sv]
/*
 * constants, register map and types for the usb link power management
 * control block.
 * assumes a 50 mhz hclk and a usb core that supplies single-cycle
 * event pulses for received lpm transactions, tokens and time-outs.
 */
package ulpm_pkg;
    // register byte offsets
    localparam logic [7:0]  CTRL_OFS        = 8'h00;
    localparam logic [7:0]  STAT_OFS        = 8'h04;
    localparam logic [7:0]  MASK_OFS        = 8'h08;
    // control register field positions
    localparam int          REQ_BIT         = 16;
    localparam int          EN_LSB          = 17;
    localparam int          EP_LSB          = 12;
    localparam int          RWAKE_BIT       = 8;
    localparam int          HOST_RESUME_DURATION_LSB        = 4;
    localparam int          LSTATE_LSB      = 0;
    localparam logic [1:0]  EN_ARMED        = 2'h3;
    localparam logic [3:0]  LSTATE_L1       = 4'h1;
    // reset values
    localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
    localparam logic [3:0]  MASK_RST        = 4'h0;
    // status / mask bit positions
    localparam int          EV_ACK          = 0;
    localparam int          EV_NYET         = 1;
    localparam int          EV_HDONE        = 2;
    localparam int          EV_HTMO         = 3;
    // host time-outs before giving up
    localparam logic [1:0]  HOST_TMO_LIMIT  = 2'h3;
    // resume drive time, in microseconds, and derived cycle counts
    localparam int          CLK_MHZ         = 50;
    localparam int          RESUME_BASE_US  = 50;
    localparam int          RESUME_STEP_US  = 75;
    localparam logic [15:0] RESUME_BASE_CYC = 16'(RESUME_BASE_US * CLK_MHZ);
    localparam logic [15:0] RESUME_STEP_CYC = 16'(RESUME_STEP_US * CLK_MHZ);

    // bus slave data-phase state
    typedef enum logic [1:0] {
        PH_IDLE    = 2'b00,
        PH_WRITE   = 2'b01,
        PH_RD_WAIT = 2'b10,
        PH_RD_DONE = 2'b11
    } ulpm_phase_type;
endpackage : ulpm_pkg

// [design/ulpm_link_if.sv]
/*
 * carrier between the register file and the link engine.
 * assumes both ends share hclk.
 */
`timescale 1ns/1ns
interface ulpm_link_if;
    logic       arm_set;    // device: req and enable written together
    logic       disarm;     // software wrote the request bit to zero
    logic       host_go;    // host: request bit written to one
    logic [3:0] link_state; // current target link state field
    logic       self_clr;   // engine clears the request bit
    logic       ev_ack;     // ack answered
    logic       ev_nyet;    // nyet answered
    logic       ev_hdone;   // host: token received
    logic       ev_htmo;    // host: gave up after time-outs

    modport regs (output arm_set, disarm, host_go, link_state,
                  input self_clr, ev_ack, ev_nyet, ev_hdone, ev_htmo);
    modport eng  (input arm_set, disarm, host_go, link_state,
                  output self_clr, ev_ack, ev_nyet, ev_hdone, ev_htmo);
endinterface : ulpm_link_if

// [design/ulpm_engine.sv]
/*
 * link engine: device-side lpm responses and host-side lpm launch.
 * assumes usb core event inputs are one-cycle pulses on hclk.
 */
`timescale 1ns/1ns
module ulpm_engine
    import ulpm_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic host_mode,
    input  wire logic lpm_rx,
    input  wire logic tx_fifo_empty,
    input  wire logic token_rx,
    input  wire logic host_timeout,
    output logic      resp_ack,
    output logic      resp_nyet,
    output logic      l1_enter,
    output logic      lpm_tx_start,
    ulpm_link_if.eng  lk
);
    logic       armed_q;   // device: waiting for next lpm transaction
    logic       busy_q;    // host: transaction outstanding
    logic [1:0] tmo_cnt_q; // host: time-outs seen
    logic       take;      // armed lpm with a valid target state

    // a reserved target state is never accepted
    assign take = !host_mode && armed_q && lpm_rx && (lk.link_state == LSTATE_L1);

    // arming needs the combined write; a zero write only disarms
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_q <= 1'b0;
        end else if (lk.arm_set) begin
            armed_q <= 1'b1;
        end else if (lk.disarm || (take && tx_fifo_empty)) begin
            armed_q <= 1'b0;
        end
    end

    // device responses, registered one-cycle pulses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resp_ack  <= 1'b0;
            resp_nyet <= 1'b0;
            l1_enter  <= 1'b0;
        end else begin
            resp_ack  <= take && tx_fifo_empty;
            resp_nyet <= take && !tx_fifo_empty;
            l1_enter  <= take && tx_fifo_empty;
        end
    end

    // host launch and completion tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_q       <= 1'b0;
            tmo_cnt_q    <= 2'h0;
            lpm_tx_start <= 1'b0;
        end else begin
            lpm_tx_start <= host_mode && lk.host_go;
            if (host_mode && lk.host_go) begin
                busy_q    <= 1'b1;
                tmo_cnt_q <= 2'h0;
            end else if (busy_q && token_rx) begin
                busy_q <= 1'b0;
            end else if (busy_q && host_timeout) begin
                tmo_cnt_q <= tmo_cnt_q + 2'h1;
                if (tmo_cnt_q + 2'h1 == HOST_TMO_LIMIT) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    // events towards the register file
    assign lk.ev_ack   = resp_ack;
    assign lk.ev_nyet  = resp_nyet;
    assign lk.ev_hdone = busy_q && token_rx && !lk.host_go;
    assign lk.ev_htmo  = busy_q && host_timeout && !token_rx && !lk.host_go
                         && (tmo_cnt_q + 2'h1 == HOST_TMO_LIMIT);
    assign lk.self_clr = lk.ev_ack || lk.ev_hdone || lk.ev_htmo;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_armed_empty_lpm;
        !host_mode && armed_q && lpm_rx && tx_fifo_empty && lk.link_state == LSTATE_L1;
    endsequence

    AST_ACK_ON_EMPTY: assert property (s_armed_empty_lpm |=> resp_ack && l1_enter && !armed_q)
        else $error("ack or disarm missing after lpm with empty fifos");
    AST_NYET_KEEPS_ARM: assert property (take && !tx_fifo_empty && !lk.disarm
                                         |=> resp_nyet && armed_q && !resp_ack)
        else $error("nyet missing or arm lost");
    AST_RESERVED_STATE: assert property (lpm_rx && lk.link_state != LSTATE_L1
                                         |=> !resp_ack && !resp_nyet)
        else $error("answered lpm with reserved link state");
    AST_HOST_LAUNCH: assert property (host_mode && lk.host_go
                                      |=> lpm_tx_start ##1 !lpm_tx_start)
        else $error("host lpm launch not one pulse");
    AST_HOST_THIRD_TMO: assert property (busy_q && !lk.host_go && !token_rx && host_timeout
                                         && tmo_cnt_q == 2'h2 |-> lk.self_clr ##1 !busy_q)
        else $error("third time-out did not clear request");
endmodule : ulpm_engine

// [testbench/ulpm_usb_partner.sv]
/*
 * usb peer model: sends lpm transactions towards the device side and
 * answers each host-mode lpm launch with a token or with time-outs.
 * assumes the bench sets the answer style before each launch.
 */
`timescale 1ns/1ns
module ulpm_usb_partner (
    input  wire logic hclk,
    input  wire logic lpm_tx_start,
    output logic      lpm_rx,
    output logic      token_rx,
    output logic      host_timeout
);
    int tmo_n = 0; // 0: answer with a token, else this many time-outs
    int delay = 1; // cycles before each answer, prompt or slow

    // quiet lines from time zero
    initial begin
        lpm_rx = 1'b0;
        token_rx = 1'b0;
        host_timeout = 1'b0;
    end

    // n back-to-back lpm transactions; held, never re-raised in one step
    task send_lpm(input int n);
        lpm_rx <= 1'b1;
        repeat (n) @(posedge hclk);
        lpm_rx <= 1'b0;
    endtask : send_lpm

    // answer each launch; a silent peer shows up as a run of time-outs
    always begin
        @(posedge hclk);
        if (lpm_tx_start === 1'b1) begin
            repeat (tmo_n == 0 ? 1 : tmo_n) begin
                repeat (delay) @(posedge hclk);
                if (tmo_n == 0) begin
                    token_rx <= 1'b1;
                end else begin
                    host_timeout <= 1'b1;
                end
                @(posedge hclk);
                token_rx <= 1'b0;
                host_timeout <= 1'b0;
            end
        end
    end
endmodule : ulpm_usb_partner

// [testbench/usb_lpm_control_tb.sv]
/*
 * self-checking bench for the lpm control block: register table rows and remote wake,
 * then device ack/nyet, refusals, host launch and mid-run reset cases.
 * assumes the one-wait-state read and zero-wait write of the slave.
 */
`timescale 1ns/1ns
module usb_lpm_control_tb;
    import ulpm_pkg::*;
    typedef struct {logic [31:0] wd; logic [31:0] rd; logic [15:0] rc;} ulpm_row_type;
    logic        hclk = 1'b0;      // 50 mhz bus clock
    logic        hresetn = 1'b0;   // active low reset
    logic        hsel = 1'b0;      // slave select
    logic [7:0]  haddr = 8'h00;    // byte address
    logic [1:0]  htrans = 2'h0;    // idle or nonseq
    logic        hwrite = 1'b0;    // write strobe
    logic [31:0] hwdata = 32'h0;   // write data
    logic [31:0] hrdata;           // read data
    logic        hreadyout;        // slave ready, also bus ready
    logic        hresp;            // slave response, always okay
    logic [2:0]  hsize = 3'h0;     // transfer size, word when active
    logic        host_mode = 1'b0; // low selects device mode
    logic        tx_fifo_empty = 1'b1; // all transmit fifos empty
    logic        suspend_end = 1'b0;   // end of current suspend
    logic        lpm_rx, token_rx, host_timeout, resp_ack, resp_nyet;
    logic        l1_enter, lpm_tx_start, sw_irq_pulse, irq, remote_wake_enable;
    logic [3:0]  lpm_endpoint, target_link_state;
    logic [15:0] resume_cycles;
    logic [31:0] rd_v;             // last read value
    int          cnt[5];           // ack, nyet, l1, irq pulse, launch
    int          miscompares = 0;
    int          n_compared = 0;
    // ordinary rows: written word, readback, resume count
    ulpm_row_type rows[3] = '{'{32'hffff_ffff, 32'h0007_f1ff, 16'd58750},
                              '{32'h0000_5a31, 32'h0000_5031, 16'd13750},
                              '{32'h0000_0100, 32'h0000_0100, 16'd2500}};

    always #10 hclk = ~hclk;

    ulpm_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .host_mode(host_mode), .lpm_rx(lpm_rx), .tx_fifo_empty(tx_fifo_empty),
        .token_rx(token_rx), .host_timeout(host_timeout), .suspend_end(suspend_end),
        .resp_ack(resp_ack), .resp_nyet(resp_nyet), .l1_enter(l1_enter),
        .lpm_tx_start(lpm_tx_start), .sw_irq_pulse(sw_irq_pulse), .irq(irq),
        .lpm_endpoint(lpm_endpoint), .remote_wake_enable(remote_wake_enable),
        .target_link_state(target_link_state), .resume_cycles(resume_cycles));

    ulpm_usb_partner peer (.hclk(hclk), .lpm_tx_start(lpm_tx_start), .lpm_rx(lpm_rx),
        .token_rx(token_rx), .host_timeout(host_timeout));

    // pulse cycles counted away from the edge, so the bench never races it
    always @(negedge hclk) begin
        if (resp_ack === 1'b1) cnt[0]++;
        if (resp_nyet === 1'b1) cnt[1]++;
        if (l1_enter === 1'b1) cnt[2]++;
        if (sw_irq_pulse === 1'b1) cnt[3]++;
        if (lpm_tx_start === 1'b1) cnt[4]++;
    end

    task give_verdict;
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
            miscompares++;
        end
    endtask : chk

    // one single transfer; each phase waits for ready under a bound
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        htrans <= 2'h2;
        for (int ph = 0; ph < 2; ph++) begin
            i = 0;
            do begin
                @(posedge hclk);
                i++;
            end while (hreadyout !== 1'b1 && i < 20);
            if (hreadyout !== 1'b1) begin
                miscompares++;
                give_verdict();
            end
            if (ph == 0) begin
                hsel <= 1'b0;
                htrans <= 2'h0;
                hwdata <= wd;
            end
        end
        rd_v = hrdata;
    endtask : ahb

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd_v, exp);
        chk(hresp, 1'b0);
    endtask : rdchk

    // pulse totals since the last clear, then clear
    task pulses(input int a, input int n, input int l, input int s, input int t);
        repeat (3) @(posedge hclk);
        chk(32'(cnt[0]), 32'(a));
        chk(32'(cnt[1]), 32'(n));
        chk(32'(cnt[2]), 32'(l));
        chk(32'(cnt[3]), 32'(s));
        chk(32'(cnt[4]), 32'(t));
        cnt = '{0, 0, 0, 0, 0};
    endtask : pulses

    initial begin
        cnt = '{0, 0, 0, 0, 0};
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(resume_cycles, 32'd2500);
        rdchk(CTRL_OFS, 32'h0);
        rdchk(STAT_OFS, 32'h0);
        rdchk(MASK_OFS, 32'h0);
        $display("reset values done");
        foreach (rows[k]) begin
            ahb(1'b1, CTRL_OFS, rows[k].wd);
            rdchk(CTRL_OFS, rows[k].rd);
            chk(lpm_endpoint, rows[k].rd[15:12]);
            chk(remote_wake_enable, rows[k].rd[8]);
            chk(resume_cycles, rows[k].rc);
            chk(target_link_state, rows[k].rd[3:0]);
        end
        suspend_end <= 1'b1;
        @(posedge hclk);
        suspend_end <= 1'b0;
        @(posedge hclk);
        chk(remote_wake_enable, 1'b0);
        ahb(1'b1, 8'h0c, 32'hffff_ffff);
        rdchk(8'h0c, 32'h0);
        rdchk(CTRL_OFS, 32'h0);
        cnt = '{0, 0, 0, 0, 0};
        $display("register rows done");
        // armed with empty fifos, interrupt masked at first
        ahb(1'b1, CTRL_OFS, 32'h0007_0001);
        peer.send_lpm(1);
        pulses(1, 0, 1, 1, 0);
        chk(irq, 1'b0);
        rdchk(CTRL_OFS, 32'h0006_0001);
        ahb(1'b1, MASK_OFS, 32'hf);
        // mask lands at the closing edge; look once it has settled
        @(posedge hclk);
        chk(irq, 1'b1);
        rdchk(STAT_OFS, 32'h1);
        chk(irq, 1'b0);
        $display("ack case done");
        // data pending: two answers in a row, request kept
        tx_fifo_empty <= 1'b0;
        ahb(1'b1, CTRL_OFS, 32'h0007_0001);
        peer.send_lpm(2);
        pulses(0, 2, 0, 2, 0);
        rdchk(CTRL_OFS, 32'h0007_0001);
        rdchk(STAT_OFS, 32'h2);
        // disarm, split writes and reserved link state all stay silent
        tx_fifo_empty <= 1'b1;
        ahb(1'b1, CTRL_OFS, 32'h0006_0001);
        peer.send_lpm(1);
        pulses(0, 0, 0, 0, 0);
        ahb(1'b1, CTRL_OFS, 32'h0001_0001);
        peer.send_lpm(1);
        pulses(0, 0, 0, 0, 0);
        ahb(1'b1, CTRL_OFS, 32'h0007_0002);
        peer.send_lpm(1);
        pulses(0, 0, 0, 0, 0);
        rdchk(STAT_OFS, 32'h0);
        $display("device refusals done");
        // host launch: slow token answer, then time-outs
        ahb(1'b1, CTRL_OFS, 32'h0);
        host_mode <= 1'b1;
        peer.delay = 6;
        ahb(1'b1, CTRL_OFS, 32'h0001_0000);
        repeat (20) @(posedge hclk);
        pulses(0, 0, 0, 0, 1);
        rdchk(CTRL_OFS, 32'h0);
        rdchk(STAT_OFS, 32'h4);
        peer.tmo_n = 2;
        peer.delay = 1;
        ahb(1'b1, CTRL_OFS, 32'h0001_0000);
        repeat (20) @(posedge hclk);
        rdchk(CTRL_OFS, 32'h0001_0000);
        peer.tmo_n = 3;
        ahb(1'b1, CTRL_OFS, 32'h0001_0000);
        repeat (20) @(posedge hclk);
        rdchk(CTRL_OFS, 32'h0);
        rdchk(STAT_OFS, 32'h8);
        pulses(0, 0, 0, 0, 2);
        $display("host case done");
        // mid-run reset with fields and mask set
        ahb(1'b1, MASK_OFS, 32'hf);
        ahb(1'b1, CTRL_OFS, 32'h0000_f1f1);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(resume_cycles, 32'd2500);
        chk(lpm_endpoint, 4'h0);
        chk(remote_wake_enable, 1'b0);
        rdchk(MASK_OFS, 32'h0);
        rdchk(CTRL_OFS, 32'h0);
        $display("mid-run reset done");
        give_verdict();
    end
endmodule : usb_lpm_control_tb
